// file: src/bwrs_pkg.sv
// Purpose: Shared constants and types for the button wake and reset sequencer
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes:   Press durations are counted in slow ticks
package bwrs_pkg;
    // Register byte offsets
    localparam logic [4:0] BWRS_CTRL_OFF = 5'h00;
    localparam logic [4:0] BWRS_TIME_OFF = 5'h04;
    localparam logic [4:0] BWRS_FLAG_OFF = 5'h08;
    localparam logic [4:0] BWRS_STAT_OFF = 5'h0c;

    typedef struct packed {
        logic [2:0] int_mask;
        logic       regulator_en;
        logic       soft_power_cycle_cmd;
        logic       adapter_watchdog_en;
        logic       adapter_required_for_reset;
        logic [1:0] long_press_action_sel;
    } bwrs_ctrl_type;

    typedef struct packed {
        logic [7:0] warning_margin_field;
        logic [7:0] long_press_timer;
        logic [7:0] second_short_press_timer;
        logic [7:0] first_short_press_timer;
    } bwrs_timing_type;

    localparam bwrs_ctrl_type   BWRS_CTRL_RESET = 9'h020;
    localparam bwrs_timing_type BWRS_TIME_RESET = 32'h32c8320a;
    localparam int              BWRS_CMD_BIT    = 4;

    // Long-press actions; bit 1 set selects shipping state
    localparam logic [1:0] BWRS_ACT_CYCLE = 2'h0;
    localparam logic [1:0] BWRS_ACT_NONE  = 2'h1;

    // Flag bit positions
    localparam int BWRS_FLAG_FIRST = 0;
    localparam int BWRS_FLAG_SECOND = 1;
    localparam int BWRS_FLAG_WARN  = 2;

    // Timing
    localparam int BWRS_CLK_MHZ         = 20;
    localparam int BWRS_INT_PULSE_US    = 128;
    localparam int BWRS_INT_PULSE_CYC   = BWRS_INT_PULSE_US * BWRS_CLK_MHZ;
    localparam int BWRS_RAIL_OFF_US     = 100;
    localparam int BWRS_RAIL_OFF_CYC    = BWRS_RAIL_OFF_US * BWRS_CLK_MHZ;
    localparam int BWRS_TICK_US         = 10000;
    localparam int BWRS_TICK_CYC        = BWRS_TICK_US * BWRS_CLK_MHZ;
    localparam int BWRS_WDOG_S          = 14;
    localparam int BWRS_WDOG_CYC        = BWRS_WDOG_S * BWRS_CLK_MHZ * 1000000;

    typedef enum logic [1:0] {
        BWRS_ST_SHIP   = 2'b00,
        BWRS_ST_WAKING = 2'b01,
        BWRS_ST_ACTIVE = 2'b10,
        BWRS_ST_CYCLE  = 2'b11
    } bwrs_state_type;
endpackage

// file: src/bwrs_top.sv
// Purpose: Pushbutton wake, short/long press timers and adapter watchdog
// Assumes: Pins are asynchronous; i2c_activity is a one-cycle pulse on aclk
// Notes:   Reset places the device in the active (powered) state
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module bwrs_top
    import bwrs_pkg::*;
#(
    parameter int TICK_CYCLES = BWRS_TICK_CYC,
    parameter int WDOG_CYCLES = BWRS_WDOG_CYC
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Pins and system inputs
    input  wire logic        wake_button_n,
    input  wire logic        adapter_valid,
    input  wire logic        battery_above_lockout,
    input  wire logic        i2c_activity,
    // Interrupt pin, open drain
    output logic             int_n_o,
    output logic             int_n_oe,
    // Power controls
    output logic             system_rail_en,
    output logic             regulator_out_en,
    output logic             logic_supply_en,
    output logic             in_ship_mode
);
    function automatic logic [31:0] bwrs_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    bwrs_ctrl_type   ctrl_reg;
    bwrs_timing_type timing_reg;
    bwrs_timing_type lat_reg;
    bwrs_state_type  state_reg;
    bwrs_state_type  state_next;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic        btn_prev_reg;
    logic        adp_prev_reg;
    logic [17:0] tick_cnt_reg;
    logic [7:0]  press_cnt_reg;
    logic        armed_reg;
    logic        adp_whole_reg;
    logic [1:0]  start_act_reg;
    logic [2:0]  flag_reg;
    logic [11:0] int_cnt_reg;
    logic [11:0] off_cnt_reg;
    logic        wd_run_reg;
    logic [28:0] wd_cnt_reg;
    logic        rail_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [4:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    // Synchronisers: first stage read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 3'h1;
            sync2_reg <= 3'h1;
        end else begin
            sync1_reg <= {battery_above_lockout, adapter_valid, wake_button_n};
            sync2_reg <= sync1_reg;
        end
    end

    logic btn_low;
    logic adp;
    logic bat_ok;
    logic fall;
    logic adp_rise;
    logic tick;
    assign btn_low  = ~sync2_reg[0];
    assign adp      = sync2_reg[1];
    assign bat_ok   = sync2_reg[2];
    assign fall     = btn_low & ~btn_prev_reg;
    assign adp_rise = adp & ~adp_prev_reg;
    assign tick     = (tick_cnt_reg == 18'(TICK_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            btn_prev_reg <= 1'b0;
            adp_prev_reg <= 1'b0;
        end else begin
            btn_prev_reg <= btn_low;
            adp_prev_reg <= adp;
        end
    end

    // Slow tick restarts at each press so expiry is measured from the fall
    always_ff @(posedge aclk) begin
        if (!aresetn || fall || tick) begin
            tick_cnt_reg <= 18'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 18'h1;
        end
    end

    // Press duration, with durations frozen at the press start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            press_cnt_reg <= 8'h0;
            lat_reg       <= BWRS_TIME_RESET;
            start_act_reg <= BWRS_ACT_NONE;
        end else if (fall) begin
            press_cnt_reg <= 8'h0;
            lat_reg       <= timing_reg;
            start_act_reg <= ctrl_reg.long_press_action_sel;
        end else if (tick && btn_low && press_cnt_reg != 8'hff) begin
            press_cnt_reg <= press_cnt_reg + 8'h1;
        end
    end

    logic [7:0] cnt_inc;
    logic [7:0] warn_at;
    logic       step;
    assign cnt_inc = press_cnt_reg + 8'h1;
    assign warn_at = lat_reg.long_press_timer - lat_reg.warning_margin_field;
    assign step    = tick & btn_low & (press_cnt_reg != 8'hff);

    // Presses begun outside active state stay disarmed until re-pressed
    always_ff @(posedge aclk) begin
        if (!aresetn || !btn_low) begin
            armed_reg <= 1'b0;
        end else if (fall) begin
            armed_reg <= (state_reg == BWRS_ST_ACTIVE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adp_whole_reg <= 1'b0;
        end else if (fall) begin
            adp_whole_reg <= adp;
        end else if (!adp) begin
            adp_whole_reg <= 1'b0;
        end
    end

    logic       live;
    logic       ev_first;
    logic       ev_second;
    logic       ev_warn;
    logic       ev_long;
    logic       wake_done;
    logic [1:0] eff_act;
    logic       cmd_pulse;
    logic       wd_expire;
    logic       do_cycle;
    logic       do_ship;
    assign live      = armed_reg & bat_ok & (state_reg == BWRS_ST_ACTIVE);
    assign ev_first  = live & step & (cnt_inc == lat_reg.first_short_press_timer);
    assign ev_second = live & step & (cnt_inc == lat_reg.second_short_press_timer);
    assign ev_warn   = live & step & (cnt_inc == warn_at)
                       & (lat_reg.long_press_timer > lat_reg.warning_margin_field);
    assign ev_long   = live & step & (cnt_inc == lat_reg.long_press_timer);
    assign wake_done = step & (cnt_inc == lat_reg.first_short_press_timer);
    // A late switch into power cycle keeps the action held at press start
    assign eff_act   = (ctrl_reg.long_press_action_sel == BWRS_ACT_CYCLE
                        && start_act_reg != BWRS_ACT_CYCLE)
                       ? start_act_reg : ctrl_reg.long_press_action_sel;
    assign do_cycle  = (ev_long && eff_act == BWRS_ACT_CYCLE
                        && (!ctrl_reg.adapter_required_for_reset || adp_whole_reg))
                       || cmd_pulse || wd_expire;
    assign do_ship   = ev_long & eff_act[1];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BWRS_ST_SHIP: begin
                if (adp) begin
                    state_next = BWRS_ST_ACTIVE;
                end else if (fall && bat_ok) begin
                    state_next = BWRS_ST_WAKING;
                end
            end
            BWRS_ST_WAKING: begin
                if (adp) begin
                    state_next = BWRS_ST_ACTIVE;
                end else if (!btn_low) begin
                    state_next = BWRS_ST_SHIP;
                end else if (wake_done) begin
                    state_next = BWRS_ST_ACTIVE;
                end
            end
            BWRS_ST_ACTIVE: begin
                if (do_cycle) begin
                    state_next = BWRS_ST_CYCLE;
                end else if (do_ship) begin
                    state_next = BWRS_ST_SHIP;
                end
            end
            BWRS_ST_CYCLE: begin
                if (off_cnt_reg == 12'(BWRS_RAIL_OFF_CYC - 1)) begin
                    state_next = BWRS_ST_ACTIVE;
                end
            end
            default: begin
                state_next = BWRS_ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= BWRS_ST_ACTIVE;
            rail_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            rail_reg  <= (state_next == BWRS_ST_ACTIVE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_reg != BWRS_ST_CYCLE) begin
            off_cnt_reg <= 12'h0;
        end else begin
            off_cnt_reg <= off_cnt_reg + 12'h1;
        end
    end

    assign system_rail_en   = rail_reg;
    assign regulator_out_en = rail_reg & ctrl_reg.regulator_en;
    assign logic_supply_en  = (state_reg != BWRS_ST_SHIP);
    assign in_ship_mode     = (state_reg == BWRS_ST_SHIP);

    // Flags and interrupt pulse
    logic [2:0] ev_v;
    logic [2:0] new_v;
    logic       rd_flags;
    logic       fire;
    assign ev_v  = {ev_warn, ev_second, ev_first};
    assign new_v = ev_v & ~flag_reg;
    assign fire  = |(new_v & ~ctrl_reg.int_mask);

    // Set wins over a read-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 3'h0;
        end else begin
            flag_reg <= (flag_reg & ~{3{rd_flags}}) | ev_v;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_cnt_reg <= 12'h0;
        end else if (fire) begin
            int_cnt_reg <= 12'(BWRS_INT_PULSE_CYC);
        end else if (int_cnt_reg != 12'h0) begin
            int_cnt_reg <= int_cnt_reg - 12'h1;
        end
    end

    assign int_n_o  = 1'b0;
    assign int_n_oe = (int_cnt_reg != 12'h0);

    // Adapter watchdog: armed by the adapter edge, stopped by any transaction
    assign wd_expire = wd_run_reg && (wd_cnt_reg == 29'(WDOG_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_run_reg <= 1'b0;
            wd_cnt_reg <= 29'h0;
        end else if (!ctrl_reg.adapter_watchdog_en || !adp || i2c_activity || wd_expire) begin
            wd_run_reg <= 1'b0;
            wd_cnt_reg <= 29'h0;
        end else if (adp_rise) begin
            wd_run_reg <= 1'b1;
            wd_cnt_reg <= 29'h0;
        end else if (wd_run_reg) begin
            wd_cnt_reg <= wd_cnt_reg + 29'h1;
        end
    end

    // AXI4-Lite slave: address and data latched independently
    logic        write_go;
    logic [31:0] wr_ctrl;
    assign awready   = ~aw_held_reg & ~bvalid;
    assign wready    = ~w_held_reg & ~bvalid;
    assign write_go  = aw_held_reg & w_held_reg;
    assign wr_ctrl   = bwrs_merge({23'h0, ctrl_reg}, wdata_reg, wstrb_reg);
    assign cmd_pulse = write_go && awaddr_reg == BWRS_CTRL_OFF && wr_ctrl[BWRS_CMD_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 5'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= {awaddr[4:2], 2'h0};
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end
            if (write_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid      <= 1'b1;
                bresp       <= awaddr_reg[4] ? 2'h2 : 2'h0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // The command bit is a trigger and never stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= BWRS_CTRL_RESET;
            timing_reg <= BWRS_TIME_RESET;
        end else if (write_go && awaddr_reg == BWRS_CTRL_OFF) begin
            ctrl_reg <= wr_ctrl[8:0] & ~(9'h001 << BWRS_CMD_BIT);
        end else if (write_go && awaddr_reg == BWRS_TIME_OFF) begin
            timing_reg <= bwrs_merge(timing_reg, wdata_reg, wstrb_reg);
        end
    end

    logic [4:0] ar_a;
    assign ar_a     = {araddr[4:2], 2'h0};
    assign arready  = ~rvalid;
    assign rd_flags = arvalid && arready && ar_a == BWRS_FLAG_OFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= ar_a[4] ? 2'h2 : 2'h0;
            case (ar_a)
                BWRS_CTRL_OFF: rdata <= {23'h0, ctrl_reg};
                BWRS_TIME_OFF: rdata <= timing_reg;
                BWRS_FLAG_OFF: rdata <= {29'h0, flag_reg};
                BWRS_STAT_OFF: rdata <= {26'h0, wd_run_reg, bat_ok, adp, btn_low, state_reg};
                default:       rdata <= 32'h0;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A later event may restart the pulse, so check the start and each step apart
    chk_pulse_start: assert property (fire |=> int_n_oe && int_cnt_reg == 12'(BWRS_INT_PULSE_CYC))
        else $error("interrupt pulse not started at full length");
    chk_pulse_count: assert property (int_n_oe && !fire |=> int_cnt_reg == $past(int_cnt_reg) - 12'h1)
        else $error("interrupt pulse counter skipped");
    chk_pulse_end: assert property ($fell(int_n_oe) |-> $past(int_cnt_reg) == 12'h1 && !$past(fire))
        else $error("interrupt pulse ended early");
    chk_flag_set: assert property (ev_first |=> flag_reg[BWRS_FLAG_FIRST])
        else $error("first flag not set on expiry");
    chk_flag_sticky: assert property (flag_reg[BWRS_FLAG_SECOND] && !rd_flags |=> flag_reg[BWRS_FLAG_SECOND])
        else $error("second flag lost without read");
    chk_int_cause: assert property ($rose(int_n_oe) |-> $past(fire))
        else $error("interrupt without a new unmasked flag");
    chk_wake_up: assert property (state_reg == BWRS_ST_WAKING && wake_done && !adp |=> system_rail_en && state_reg == BWRS_ST_ACTIVE)
        else $error("wake expiry did not power rail");
    chk_wake_dark: assert property (state_reg == BWRS_ST_WAKING |-> !system_rail_en && !regulator_out_en)
        else $error("rail powered during wake count");
    chk_adapter_exit: assert property (!state_reg[1] && adp |=> state_reg == BWRS_ST_ACTIVE)
        else $error("adapter did not leave shipping state");
    chk_cycle_supply: assert property (state_reg == BWRS_ST_CYCLE |-> logic_supply_en && !system_rail_en)
        else $error("power cycle state wrong");
    // Off time is judged on the off counter rather than a long delay
    chk_cycle_return: assert property (state_reg == BWRS_ST_CYCLE && off_cnt_reg == 12'(BWRS_RAIL_OFF_CYC - 1) |=> system_rail_en)
        else $error("rail not restored after power cycle");
    chk_cycle_hold: assert property (state_reg == BWRS_ST_CYCLE && off_cnt_reg != 12'(BWRS_RAIL_OFF_CYC - 1) |=> !system_rail_en)
        else $error("rail restored before off time");
    chk_wdog_off: assert property (!ctrl_reg.adapter_watchdog_en |=> !wd_run_reg)
        else $error("watchdog running while disabled");

    cov_wake: cover property (state_reg == BWRS_ST_WAKING ##1 state_reg == BWRS_ST_ACTIVE);
    cov_long_cycle: cover property (ev_long && do_cycle);
    cov_long_ship: cover property (do_ship);
    cov_wdog: cover property (wd_expire);
endmodule
`default_nettype wire

// file: testbench/bwrs_partner.sv
// Purpose: Pushbutton and host bus activity model for the sequencer
// Assumes: Button pin has a pull-up, so a released button reads high
// Notes:   Pins change only just after rising edges
`timescale 1ns/10ps
`default_nettype none
module bwrs_partner (
    // Clock
    input  wire logic aclk,
    // Far side pins
    output var logic  wake_button_n,
    output var logic  i2c_activity
);
    initial begin
        wake_button_n = 1'b1;
        i2c_activity  = 1'b0;
    end

    // Pull-up returns the pin high on release
    task automatic press(input int n);
        @(posedge aclk);
        wake_button_n <= 1'b0;
        repeat (n) @(posedge aclk);
        wake_button_n <= 1'b1;
    endtask

    task automatic bus_hit();
        @(posedge aclk);
        i2c_activity <= 1'b1;
        @(posedge aclk);
        i2c_activity <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: testbench/button_wake_reset_sequencer_test.sv
// Purpose: Self-checking bench for the button wake and reset sequencer
// Assumes: Short tick and watchdog counts so the run stays brief
// Notes:   Timing register fields below are counted in slow ticks of 4 cycles
`timescale 1ns/10ps
`default_nettype none
module button_wake_reset_sequencer_test;
    import bwrs_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, adapter_valid, batt_ok;
    logic [4:0]  awaddr, araddr;
    logic [3:0]  wstrb, ws;
    logic [31:0] wdata, rd;
    logic [1:0]  rr, br;
    logic        s, r;
    wire logic   awready, wready, bvalid, arready, rvalid, int_n_o, int_n_oe;
    wire logic   rail, reg_out, lsup, ship, btn_n, i2c;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    int          error_cnt, cmp_count, cyc, hi;

    bwrs_top #(.TICK_CYCLES(4), .WDOG_CYCLES(200)) uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wake_button_n(btn_n), .adapter_valid(adapter_valid),
        .battery_above_lockout(batt_ok), .i2c_activity(i2c), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe), .system_rail_en(rail), .regulator_out_en(reg_out),
        .logic_supply_en(lsup), .in_ship_mode(ship));
    bwrs_partner p (.aclk(aclk), .wake_button_n(btn_n), .i2c_activity(i2c));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Generous ceiling, the full run needs about 17500 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        check({31'h0, g}, {31'h0, e});
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= ws;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata; rr = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        rdr(a);
        check(rd, e);
    endtask

    task automatic watch(input int n);
        hi = 0; s = 1'b0; r = 1'b0;
        repeat (n) begin
            @(posedge aclk);
            hi += int'(int_n_oe === 1'b1);
            s |= lsup; r |= rail | reg_out;
        end
    endtask

    // Long press: action c0 at the fall, c1 written mid-press
    task automatic lp(input logic [31:0] c0, c1, input logic er, el);
        wr(BWRS_CTRL_OFF, c0);
        fork p.press(70); join_none
        repeat (20) @(posedge aclk);
        wr(BWRS_CTRL_OFF, c1);
        repeat (25) @(posedge aclk);
        chk1(rail, er);
        chk1(lsup, el);
        repeat (2200) @(posedge aclk);
    endtask

    task automatic t_short();
        wr(BWRS_TIME_OFF, 32'h030a0402);
        fork p.press(12); watch(3000); join
        check(32'(hi), 32'ha00);
        chk1(int_n_o, 1'b0);
        fork p.press(12); watch(100); join
        check(32'(hi), 32'h0);
        rd_chk(BWRS_FLAG_OFF, 32'h1);
        rd_chk(BWRS_FLAG_OFF, 32'h0);
        wr(BWRS_CTRL_OFF, 32'h060);
        fork p.press(12); watch(100); join
        check(32'(hi), 32'h0);
        rd_chk(BWRS_FLAG_OFF, 32'h1);
        batt_ok <= 1'b0;
        repeat (4) @(posedge aclk);
        p.press(20);
        rd_chk(BWRS_FLAG_OFF, 32'h0);
        batt_ok <= 1'b1;
        $display("short press test done");
    endtask

    task automatic t_long();
        lp(32'h020, 32'h020, 1'b0, 1'b1);
        chk1(rail, 1'b1);
        rd_chk(BWRS_FLAG_OFF, 32'h7);
        lp(32'h021, 32'h020, 1'b1, 1'b1);
        lp(32'h024, 32'h024, 1'b1, 1'b1);
        $display("long press test done");
    endtask

    task automatic t_ship();
        lp(32'h022, 32'h022, 1'b0, 1'b0);
        chk1(ship, 1'b1);
        fork p.press(4); watch(30); join
        chk1(s, 1'b1);
        chk1(r, 1'b0);
        chk1(ship, 1'b1);
        fork p.press(120); join_none
        repeat (30) @(posedge aclk);
        check({reg_out, rail}, 2'b11);
        repeat (100) @(posedge aclk);
        check({ship, rail}, 2'b01);
        lp(32'h022, 32'h022, 1'b0, 1'b0);
        adapter_valid <= 1'b1;
        repeat (5) @(posedge aclk);
        check({ship, rail}, 2'b01);
        $display("ship test done");
    endtask

    task automatic t_soft();
        wr(BWRS_CTRL_OFF, 32'h030);
        repeat (3) @(posedge aclk);
        check({rail, lsup}, 2'b01);
        repeat (2100) @(posedge aclk);
        chk1(rail, 1'b1);
        rd_chk(BWRS_CTRL_OFF, 32'h020);
        wr(BWRS_CTRL_OFF, 32'h028);
        adapter_valid <= 1'b0;
        repeat (5) @(posedge aclk);
        adapter_valid <= 1'b1;
        repeat (100) @(posedge aclk);
        p.bus_hit();
        repeat (200) @(posedge aclk);
        chk1(rail, 1'b1);
        adapter_valid <= 1'b0;
        repeat (5) @(posedge aclk);
        adapter_valid <= 1'b1;
        repeat (260) @(posedge aclk);
        check({rail, lsup}, 2'b01);
        $display("power cycle test done");
    endtask

    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; adapter_valid = 1'b0; batt_ok = 1'b1;
        awaddr = 5'h0; araddr = 5'h0; wstrb = 4'h0; wdata = 32'h0;
        ws = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(BWRS_CTRL_OFF, 32'(BWRS_CTRL_RESET));
        rd_chk(BWRS_TIME_OFF, 32'(BWRS_TIME_RESET));
        rd_chk(5'h10, 32'h0);
        check(32'(rr), 32'h2);
        wr(5'h10, 32'h0);
        check(32'(br), 32'h2);
        ws = 4'h2;
        wr(BWRS_TIME_OFF, 32'hffffffff);
        check(32'(br), 32'h0);
        rd_chk(BWRS_TIME_OFF, 32'h32c8ff0a);
        ws = 4'hf;
        $display("reset test done");
        t_short();
        t_long();
        t_ship();
        t_soft();
        end_sim();
    end
endmodule
`default_nettype wire
